// ==== cms_defines.svh ====
// constants for the counter mode sequencer
// Notes on behaviour
// - gated delayed pulse counts only while gate
// - load to tc, hold to tc, disarm
// - strobe starts on arm plus gate edge
// - later gate activity ignored after trigger
// - ungated duty cycle repeats load/hold forever
// - toggle output: load level, then hold level
// - level gated duty cycle stops without gate
// - each gate edge while waiting starts one load-hold cycle
// - after cycle stays armed awaiting gate edge
// - level retrigger: tc with gate reloads, disarms
// - gate reassert saves count, reloads next edge
// - edge retrigger reloads on next source edge
// - edge retrigger: tc reloads load, disarms
// - sync rate generator counts only while gated
// - gate edge reloads, resumes second source edge
// - retrigger one-shot saves count, reloads load
// - retrigger one-shot ignores gate level
// - gate strobe counts tc twice, disarms
// - tc reloads hold if gate high, else load
// - fsk counts continuously, gate picks source
// - hardware save: gate edge starts, runs to tc
// - save edges copy count; unarmed ignores edges
// - software delayed pulse: load, hold, disarm
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH
`define CMS_GC_NONE 3'h0
`define CMS_GC_EDGE_LO 3'h6
`define CMS_ONE 16'h0001
`define CMS_ZERO 16'h0000
`endif

// ==== cms_pkg.sv ====
// types for the counter mode sequencer
package cms_pkg;
   typedef enum logic [1:0] {CMS_IDLE, CMS_RUN, CMS_WAIT} cms_phase_t;
   typedef enum logic [3:0] {
      CMS_M_G, CMS_M_H, CMS_M_I, CMS_M_J, CMS_M_K, CMS_M_L,
      CMS_M_N, CMS_M_O, CMS_M_Q, CMS_M_R, CMS_M_S, CMS_M_V, CMS_M_X, CMS_M_OFF
   } cms_mode_t;
   typedef struct packed {
      logic       special_gate_bit;
      logic       reload_source_bit;
      logic       repetition_bit;
      logic [2:0] gate_control_field;
   } cms_cfg_t;
   typedef struct packed {
      logic arm;
      logic disarm;
   } cms_cmd_t;
endpackage : cms_pkg

// ==== cms_mode_decode.sv ====
// decodes mode setting bits into an operating mode
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"
module cms_mode_decode
   import cms_pkg::*;
(
   // mode setting
   input  wire cms_cfg_t  cfg,
   // decoded mode
   output cms_mode_t      mode
);
   // gate field zero means no gating, else level or edge gating
   always_comb begin
      logic none;
      logic lvl;
      none = (cfg.gate_control_field == `CMS_GC_NONE);
      lvl  = !none && (cfg.gate_control_field < `CMS_GC_EDGE_LO);
      mode = CMS_M_OFF;
      case ({cfg.special_gate_bit, cfg.reload_source_bit, cfg.repetition_bit})
         3'h2: mode = none ? CMS_M_G : (lvl ? CMS_M_H : CMS_M_I);
         3'h3: mode = none ? CMS_M_J : (lvl ? CMS_M_K : CMS_M_L);
         3'h4: mode = none ? CMS_M_OFF : (lvl ? CMS_M_N : CMS_M_O);
         3'h5: mode = none ? CMS_M_OFF : (lvl ? CMS_M_Q : CMS_M_R);
         3'h6: mode = none ? CMS_M_S : CMS_M_OFF;
         3'h7: mode = none ? CMS_M_V : (lvl ? CMS_M_OFF : CMS_M_X);
         default: mode = CMS_M_OFF;
      endcase
   end
endmodule : cms_mode_decode
`default_nettype wire

// ==== cms_edge_detect.sv ====
// rising-edge detector for gate and count source samples
`timescale 1ns/1ps
`default_nettype none
module cms_edge_detect (
   // clocking
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic ce,
   // level in, pulse out
   input  wire logic level,
   output logic      rise
);
   logic prev;
   // previous sample; frozen while the enable is low
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prev <= 1'b0;
      end else if (ce) begin
         prev <= level;
      end
   end
   assign rise = ce && level && !prev;
endmodule : cms_edge_detect
`default_nettype wire

// ==== cms_counter_mode_sequencer.sv ====
// mode g to x sequencer for one 16-bit counter
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"
module cms_counter_mode_sequencer
   import cms_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clocking
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   input  wire logic             ce,
   // configuration
   input  wire cms_cfg_t         cfg,
   input  wire logic [WIDTH-1:0] load_value,
   input  wire logic [WIDTH-1:0] hold_value,
   // software commands
   input  wire cms_cmd_t         cmd,
   // external gate and active count source level
   input  wire logic             gate,
   input  wire logic             count_src,
   // status
   output logic [WIDTH-1:0]      count,
   output logic [WIDTH-1:0]      hold_save,
   output logic                  hold_save_valid,
   output logic                  armed,
   output logic                  running,
   output logic                  terminal_count,
   output logic                  toggle_out,
   output logic                  in_hold_phase
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic [WIDTH-1:0] hsave;
      logic             hvalid;
      logic             armed;
      cms_phase_t       phase;
      logic             second;     // counting the hold value
      logic             tc;
      logic             tog;
      logic             reload_pend; // reload from load on next source edge
      logic             skip_one;    // swallow one source edge (sync mode)
      logic             halted;      // level-retrigger counter halted by gate
   } cms_state_t;

   cms_state_t st;
   cms_state_t next_st;
   cms_mode_t  mode;
   logic       src_edge;
   logic       gate_edge;

   cms_mode_decode u_dec (
      .cfg  (cfg),
      .mode (mode)
   );

   cms_edge_detect u_src (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .ce      (ce),
      .level   (count_src),
      .rise    (src_edge)
   );

   cms_edge_detect u_gate (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .ce      (ce),
      .level   (gate),
      .rise    (gate_edge)
   );

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // modes whose tc alternates load and hold
   function automatic logic alt_mode(input cms_mode_t m);
      alt_mode = (m == CMS_M_G) || (m == CMS_M_H) || (m == CMS_M_I) ||
                 (m == CMS_M_J) || (m == CMS_M_K) || (m == CMS_M_L);
   endfunction : alt_mode

   // modes that need a gate edge to leave the waiting phase
   function automatic logic edge_start(input cms_mode_t m);
      edge_start = (m == CMS_M_I) || (m == CMS_M_L) || (m == CMS_M_O) ||
                   (m == CMS_M_R) || (m == CMS_M_X);
   endfunction : edge_start

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      logic gate_ok;
      logic at_tc;
      next_st    = st;
      next_st.tc = 1'b0;
      gate_ok    = 1'b1;
      at_tc      = (st.cnt == WIDTH'(`CMS_ONE)) || (st.cnt == WIDTH'(`CMS_ZERO));
      // level gating inhibits counting
      if ((mode == CMS_M_H) || (mode == CMS_M_K) || (mode == CMS_M_Q)) begin
         gate_ok = gate;
      end
      case (st.phase)
         CMS_IDLE: begin
            if (cmd.arm && mode != CMS_M_OFF) begin
               next_st.armed  = 1'b1;
               next_st.second = 1'b0;
               next_st.cnt    = load_value;
               next_st.halted = 1'b0;
               // edge modes wait for a gate edge, level retrigger for gate
               if (edge_start(mode) || mode == CMS_M_N) begin
                  next_st.phase = CMS_WAIT;
               end else begin
                  next_st.phase = CMS_RUN;
               end
            end
         end
         CMS_WAIT: begin
            // armed, stopped; gate start
            if ((edge_start(mode) && gate_edge) || (mode == CMS_M_N && gate)) begin
               next_st.phase  = CMS_RUN;
               next_st.second = 1'b0;
               next_st.cnt    = load_value;
            end
         end
         CMS_RUN: begin
            // gate edges while counting, per mode
            if (gate_edge) begin
               case (mode)
                  CMS_M_O: next_st.reload_pend = 1'b1;
                  CMS_M_Q: begin
                     next_st.cnt      = load_value;
                     next_st.skip_one = 1'b1;
                  end
                  CMS_M_R: begin
                     next_st.hsave  = st.cnt;
                     next_st.hvalid = 1'b1;
                     next_st.cnt    = load_value;
                  end
                  CMS_M_X: begin
                     next_st.hsave  = st.cnt;
                     next_st.hvalid = 1'b1;
                  end
                  default: ;  // other modes ignore edges while running
               endcase
            end
            // level retrigger: gate drop halts, reassert saves count
            if (mode == CMS_M_N) begin
               if (!gate) begin
                  next_st.halted = 1'b1;
               end else if (st.halted) begin
                  next_st.halted      = 1'b0;
                  next_st.hsave       = st.cnt;
                  next_st.hvalid      = 1'b1;
                  next_st.reload_pend = 1'b1;
               end
            end
            // count actions ride the source edge, except the mode q and r gate-edge reloads above
            if (src_edge && gate_ok && !(mode == CMS_M_N && (st.halted || !gate))
                && !(gate_edge && (mode == CMS_M_Q || mode == CMS_M_R))) begin
               if (st.skip_one) begin
                  next_st.skip_one = 1'b0;  // resume on second edge
               end else if (st.reload_pend) begin
                  // a fresh gate edge in this cycle keeps its request pending
                  next_st.reload_pend = gate_edge && (mode == CMS_M_O);
                  next_st.cnt         = load_value;
               end else if (!at_tc) begin
                  next_st.cnt = st.cnt - WIDTH'(`CMS_ONE);
               end else begin
                  next_st.tc = 1'b1;
                  if (alt_mode(mode)) begin
                     // alternate load/hold
                     next_st.second = !st.second;
                     next_st.tog    = !st.tog;   // load level then hold level
                     next_st.cnt    = st.second ? load_value : hold_value;
                     if (st.second) begin
                        if (mode == CMS_M_L) begin
                           next_st.phase = CMS_WAIT;  // stay armed
                        end else if (mode != CMS_M_J && mode != CMS_M_K) begin
                           next_st.phase = CMS_IDLE;
                           next_st.armed = 1'b0;
                        end
                     end
                  end else if (mode == CMS_M_S || mode == CMS_M_V) begin
                     // gate picks reload source
                     next_st.cnt    = gate ? hold_value : load_value;
                     next_st.tog    = !st.tog;
                     next_st.second = !st.second;
                     if (mode == CMS_M_S && st.second) begin  // twice then disarm
                        next_st.phase = CMS_IDLE;
                        next_st.armed = 1'b0;
                     end
                  end else begin
                     next_st.cnt = load_value;
                     next_st.tog = !st.tog;
                     if (mode == CMS_M_N || mode == CMS_M_O) begin
                        next_st.phase = CMS_IDLE;
                        next_st.armed = 1'b0;
                     end else if (mode == CMS_M_R || mode == CMS_M_X) begin
                        next_st.phase = CMS_WAIT;  // stop until edge
                     end
                  end
               end
            end
         end
         default: next_st.phase = CMS_IDLE;
      endcase
      // disarm command wins over arm and all phase changes; count and save updates still land
      if (cmd.disarm) begin
         next_st.armed       = 1'b0;
         next_st.phase       = CMS_IDLE;
         next_st.reload_pend = 1'b0;
         next_st.skip_one    = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // state register, frozen while ce is low
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '{cnt: WIDTH'(`CMS_ZERO), hsave: WIDTH'(`CMS_ZERO), phase: CMS_IDLE,
                 default: 1'b0};
      end else if (ce) begin
         st <= next_st;
      end
   end

   // outputs from flip-flops; running is decoded from the phase register
   assign count           = st.cnt;
   assign hold_save       = st.hsave;
   assign hold_save_valid = st.hvalid;
   assign armed           = st.armed;
   assign running         = (st.phase == CMS_RUN);
   assign terminal_count  = st.tc;
   assign toggle_out      = st.tog;
   assign in_hold_phase   = st.second;
endmodule : cms_counter_mode_sequencer
`default_nettype wire

// ==== cms_ext_source.sv ====
// gate line and count source driven from outside the counter
`timescale 1ns/1ps
`default_nettype none
module cms_ext_source (
   // clocking
   input  wire logic sys_clk,
   // lines into the counter
   output var logic  gate,
   output var logic  count_src
);
   // ---------------------------------------------
   // stimulus tasks, all moves on the falling edge
   // ---------------------------------------------
   initial begin
      gate = 1'b0;
      count_src = 1'b0;
   end
   // one source edge; low again so the next edge is seen
   task automatic src_edge();
      @(negedge sys_clk) count_src = 1'b1;
      @(negedge sys_clk) count_src = 1'b0;
      @(negedge sys_clk);
   endtask : src_edge
   // gate level, settled after one sampling edge
   task automatic set_gate(input logic v);
      @(negedge sys_clk) gate = v;
      @(negedge sys_clk);
   endtask : set_gate
endmodule : cms_ext_source
`default_nettype wire

// ==== cms_counter_mode_sequencer_chk.sv ====
// assertions for the counter mode sequencer
`timescale 1ns/1ps
`default_nettype none
module cms_counter_mode_sequencer_chk
   import cms_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clocking
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   input  wire logic             ce,
   // stimulus
   input  wire cms_cfg_t         cfg,
   input  wire logic [WIDTH-1:0] load_value,
   input  wire logic [WIDTH-1:0] hold_value,
   input  wire cms_cmd_t         cmd,
   input  wire logic             gate,
   input  wire logic             count_src,
   // status
   input  wire logic [WIDTH-1:0] count,
   input  wire logic [WIDTH-1:0] hold_save,
   input  wire logic             armed,
   input  wire logic             running,
   input  wire logic             terminal_count,
   input  wire logic             toggle_out
);
   // ---------------------------------------------
   // edge view matching the sequencer's own sampling
   // ---------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   // frozen cycles carry no obligations
   default disable iff (!nrst || !ce);
   logic src_q, gate_q, src_rise, gate_rise;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         src_q <= 1'b0;
         gate_q <= 1'b0;
      end else if (ce) begin
         src_q <= count_src;
         gate_q <= gate;
      end
   end
   assign src_rise = count_src & ~src_q;
   assign gate_rise = gate & ~gate_q;
   a_disarm_stops: assert property (
      cmd.disarm |=> !armed && !running) else $error("disarm left counter active");
   a_gated_hold: assert property (
      cfg inside {6'h11, 6'h19, 6'h21, 6'h29} && !gate && src_rise |=> $stable(count))
      else $error("count moved with gate low");
   a_strobe_wait: assert property (
      cfg == 6'h16 && !running && !gate_rise && !cmd.arm |=> !running)
      else $error("strobe ran without gate edge");
   a_reload_pick: assert property (
      cfg == 6'h30 && terminal_count |->
      count == ($past(gate) ? $past(hold_value) : $past(load_value)))
      else $error("reload source not chosen by gate");
   a_toggle_flip: assert property (
      terminal_count |-> toggle_out != $past(toggle_out)) else $error("toggle missed tc");
   a_tc_single: assert property (
      terminal_count |=> !terminal_count) else $error("tc longer than one cycle");
   a_count_quiet: assert property (
      !src_rise && $stable(gate) && $stable(cfg) && !cmd.arm && !cmd.disarm
      |=> $stable(count)) else $error("count moved without source edge");
   a_save_running: assert property (
      cfg == 6'h3E && running && gate_rise && !src_rise
      |=> hold_save == $past(count) && $stable(count)) else $error("save wrong");
   a_retrig_load: assert property (
      cfg == 6'h2E && running && gate_rise && !src_rise
      |=> count == $past(load_value) && hold_save == $past(count))
      else $error("retrigger wrong");
   a_unarmed_idle: assert property (
      !armed && !cmd.arm |=> !running) else $error("ran while unarmed");
endmodule : cms_counter_mode_sequencer_chk
bind cms_counter_mode_sequencer cms_counter_mode_sequencer_chk #(.WIDTH(WIDTH)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .cfg(cfg), .load_value(load_value),
   .hold_value(hold_value), .cmd(cmd), .gate(gate), .count_src(count_src),
   .count(count), .hold_save(hold_save), .armed(armed), .running(running),
   .terminal_count(terminal_count), .toggle_out(toggle_out));
`default_nettype wire

// ==== cms_counter_mode_sequencer_tb.sv ====
// self-checking bench for the counter mode sequencer
`timescale 1ns/1ps
`default_nettype none
module cms_counter_mode_sequencer_tb
   import cms_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        ce = 1'b1;
   cms_cfg_t    cfg = 6'h00;
   logic [15:0] load_value = 16'h0000;
   logic [15:0] hold_value = 16'h0000;
   cms_cmd_t    cmd = 2'h0;
   logic        gate, count_src, hsv, armed, running, tc, tog, inh, t0;
   logic [15:0] count, hold_save;
   int          fails = 0;
   int          n_tests = 0;
   always #5 sys_clk = ~sys_clk;
   cms_ext_source u_ext (.sys_clk(sys_clk), .gate(gate), .count_src(count_src));
   cms_counter_mode_sequencer u_dut (
      .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .cfg(cfg), .load_value(load_value),
      .hold_value(hold_value), .cmd(cmd), .gate(gate), .count_src(count_src),
      .count(count), .hold_save(hold_save), .hold_save_valid(hsv), .armed(armed),
      .running(running), .terminal_count(tc), .toggle_out(tog), .in_hold_phase(inh));
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // mode change in the same cycle as a disarm pulse, then one arm pulse
   task automatic start(input logic [5:0] c, input logic [15:0] l, input logic [15:0] h);
      @(negedge sys_clk) cmd = 2'h1;
      cfg = c;
      load_value = l;
      hold_value = h;
      @(negedge sys_clk) cmd = 2'h2;
      @(negedge sys_clk) cmd = 2'h0;
      @(negedge sys_clk);
   endtask : start
   // hang guard; every wait below is a fixed cycle count
   initial begin
      #500000;
      fails++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk) nrst = 1'b1;
      start(6'h10, 16'h0002, 16'h0003);
      chk("g count", 16'h0002, count);
      repeat (2) u_ext.src_edge();
      chk("g hold", 16'h0003, count);
      repeat (3) u_ext.src_edge();
      chk("g end", 16'h0002, count);
      chk("g armed", 16'h0000, 16'(armed));
      start(6'h11, 16'h0003, 16'h0002);
      u_ext.src_edge();
      chk("h gated", 16'h0003, count);
      u_ext.set_gate(1'b1);
      repeat (3) u_ext.src_edge();
      chk("h hold", 16'h0002, count);
      repeat (2) u_ext.src_edge();
      chk("h armed", 16'h0000, 16'(armed));
      start(6'h18, 16'h0002, 16'h0003);
      t0 = tog;
      repeat (2) u_ext.src_edge();
      chk("j phase", 16'h0001, 16'(inh));
      chk("j toggle", 16'(!t0), 16'(tog));
      repeat (3) u_ext.src_edge();
      chk("j reload", 16'h0002, count);
      chk("j armed", 16'h0001, 16'(armed));
      u_ext.set_gate(1'b0);
      start(6'h16, 16'h0002, 16'h0001);
      u_ext.src_edge();
      chk("i wait", 16'h0002, count);
      u_ext.set_gate(1'b1);
      u_ext.src_edge();
      u_ext.set_gate(1'b0);
      u_ext.set_gate(1'b1);
      chk("i ignore", 16'h0001, count);
      repeat (2) u_ext.src_edge();
      chk("i armed", 16'h0000, 16'(armed));
      u_ext.set_gate(1'b0);
      start(6'h1E, 16'h0002, 16'h0001);
      u_ext.set_gate(1'b1);
      repeat (4) u_ext.src_edge();
      chk("l stop", 16'h0002, count);
      chk("l armed", 16'h0001, 16'(armed));
      u_ext.set_gate(1'b0);
      u_ext.set_gate(1'b1);
      u_ext.src_edge();
      chk("l again", 16'h0001, count);
      start(6'h30, 16'h0002, 16'h0003);
      repeat (2) u_ext.src_edge();
      chk("s hold", 16'h0003, count);
      u_ext.set_gate(1'b0);
      repeat (3) u_ext.src_edge();
      chk("s load", 16'h0002, count);
      chk("s armed", 16'h0000, 16'(armed));
      start(6'h3E, 16'h0004, 16'h0001);
      u_ext.set_gate(1'b1);
      u_ext.src_edge();
      u_ext.set_gate(1'b0);
      u_ext.set_gate(1'b1);
      chk("x save", 16'h0003, hold_save);
      chk("x count", 16'h0003, count);
      chk("x valid", 16'h0001, 16'(hsv));
      repeat (3) u_ext.src_edge();
      chk("x stop", 16'h0000, 16'(running));
      u_ext.set_gate(1'b0);
      start(6'h2E, 16'h0005, 16'h0001);
      u_ext.set_gate(1'b1);
      repeat (2) u_ext.src_edge();
      u_ext.set_gate(1'b0);
      u_ext.set_gate(1'b1);
      chk("r reload", 16'h0005, count);
      chk("r save", 16'h0003, hold_save);
      u_ext.set_gate(1'b0);
      u_ext.src_edge();
      chk("r level", 16'h0004, count);
      // edge retrigger: reload waits for the next source edge
      start(6'h26, 16'h0005, 16'h0001);
      u_ext.set_gate(1'b1);
      repeat (2) u_ext.src_edge();
      u_ext.set_gate(1'b0);
      u_ext.set_gate(1'b1);
      chk("o pend", 16'h0003, count);
      u_ext.src_edge();
      chk("o retrig", 16'h0005, count);
      repeat (5) u_ext.src_edge();
      chk("o armed", 16'h0000, 16'(armed));
      chk("o reload", 16'h0005, count);
      // level retrigger: halt on gate drop, save on reassert
      u_ext.set_gate(1'b0);
      start(6'h21, 16'h0004, 16'h0001);
      u_ext.src_edge();
      chk("n wait", 16'h0004, count);
      u_ext.set_gate(1'b1);
      u_ext.src_edge();
      u_ext.set_gate(1'b0);
      u_ext.src_edge();
      chk("n halt", 16'h0003, count);
      u_ext.set_gate(1'b1);
      chk("n save", 16'h0003, hold_save);
      u_ext.src_edge();
      chk("n reload", 16'h0004, count);
      repeat (4) u_ext.src_edge();
      chk("n armed", 16'h0000, 16'(armed));
      // synchronised rate generator
      start(6'h29, 16'h0003, 16'h0001);
      u_ext.src_edge();
      u_ext.set_gate(1'b0);
      u_ext.src_edge();
      chk("q inhibit", 16'h0002, count);
      u_ext.set_gate(1'b1);
      chk("q sync", 16'h0003, count);
      u_ext.src_edge();
      chk("q swallow", 16'h0003, count);
      repeat (3) u_ext.src_edge();
      chk("q repeat", 16'h0003, count);
      chk("q armed", 16'h0001, 16'(armed));
      // level gated duty cycle
      start(6'h19, 16'h0002, 16'h0001);
      u_ext.set_gate(1'b0);
      u_ext.src_edge();
      chk("k gated", 16'h0002, count);
      u_ext.set_gate(1'b1);
      repeat (2) u_ext.src_edge();
      chk("k hold", 16'h0001, count);
      chk("k phase", 16'h0001, 16'(inh));
      // gate picks reload source, runs on
      start(6'h38, 16'h0002, 16'h0003);
      repeat (2) u_ext.src_edge();
      chk("v hold", 16'h0003, count);
      u_ext.set_gate(1'b0);
      repeat (3) u_ext.src_edge();
      chk("v load", 16'h0002, count);
      chk("v armed", 16'h0001, 16'(armed));
      // enable low freezes state and edge sampling
      @(negedge sys_clk) ce = 1'b0;
      u_ext.src_edge();
      @(negedge sys_clk) ce = 1'b1;
      @(negedge sys_clk);
      chk("ce frozen", 16'h0002, count);
      u_ext.src_edge();
      chk("ce resume", 16'h0001, count);
      // reset again in mid-run
      @(negedge sys_clk) nrst = 1'b0;
      @(negedge sys_clk) nrst = 1'b1;
      @(negedge sys_clk);
      chk("rst count", 16'h0000, count);
      chk("rst armed", 16'h0000, 16'(armed));
      finish_test();
   end
endmodule : cms_counter_mode_sequencer_tb
`default_nettype wire
